// file: hw/ptptr_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "ptptr_regs.vh"
// Notes on behaviour
// - Port 1 tx latency, reset 45 ns
// - Asymmetry is sign plus 15-bit magnitude
// - Ingress Sync/Pdelay_Resp add asymmetry to correction
// - Egress Delay_Req/Pdelay_Req subtract asymmetry
// - Port 1 link delay, reset zero, writable
// - Delay request stamp low: ns 15..0
// - Delay request stamp high: sec 1..0, ns 29..16
// - Sync stamp low: ns 15..0
// - Sync stamp high: sec 1..0, ns 29..16
// - Peer response stamp low: ns 15..0
// - Peer response stamp high: sec 1..0, ns 29..16
// - Port 2 rx latency, reset 415 ns
// - Port 1 rx latency, reset 415 ns
module ptptr_regs (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_wr,
  input wire i_rd,
  input wire [11:0] i_addr,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  output reg o_rvalid,
  input wire i_egr_dreq,
  input wire i_egr_sync,
  input wire i_egr_prsp,
  input wire [1:0] i_egr_sec,
  input wire [29:0] i_egr_ns,
  input wire i_corr_valid,
  input wire i_corr_ingress,
  input wire [63:0] i_corr_in,
  output reg [63:0] o_corr_out,
  output reg o_corr_valid,
  output wire [15:0] o_port1_tx_latency,
  output wire [15:0] o_port1_rx_latency,
  output wire [15:0] o_port1_link_delay,
  output wire [15:0] o_port2_rx_latency
);
  reg [15:0] port1_rx_latency_q;
  reg [15:0] port1_tx_latency_q;
  reg [15:0] port1_asymmetry_correction_q;
  reg [15:0] port1_link_delay_q;
  reg [15:0] port2_rx_latency_q;
  reg [15:0] cfg_rdata_q;
  reg cfg_hit_q;
  reg [2:0] wr_slot_d;
  reg wr_hi_d;
  reg [1:0] rd_slot_d;
  reg rd_hi_d;
  reg [63:0] asym_ext;
  wire [15:0] mem_rdata;
  wire [2:0] cap;

  //////////////////////////////////////////////////////////////////////
  // Configuration registers, host writes whole 16-bit words
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      port1_rx_latency_q <= `PTPTR_RST_RX_LAT;
      port1_tx_latency_q <= `PTPTR_RST_TX_LAT;
      port1_asymmetry_correction_q <= `PTPTR_RST_ZERO;
      port1_link_delay_q <= `PTPTR_RST_ZERO;
      port2_rx_latency_q <= `PTPTR_RST_RX_LAT;
    end else if (i_wr) begin
      case (i_addr)
        `PTPTR_OFS_P1_RX_LAT: port1_rx_latency_q <= i_wdata;
        `PTPTR_OFS_P1_TX_LAT: port1_tx_latency_q <= i_wdata;
        `PTPTR_OFS_P1_ASYM: port1_asymmetry_correction_q <= i_wdata;
        `PTPTR_OFS_P1_LINK_DLY: port1_link_delay_q <= i_wdata;
        `PTPTR_OFS_P2_RX_LAT: port2_rx_latency_q <= i_wdata;
        default: ;
      endcase
    end
  end

  assign o_port1_tx_latency = port1_tx_latency_q;
  assign o_port1_rx_latency = port1_rx_latency_q;
  assign o_port1_link_delay = port1_link_delay_q;
  assign o_port2_rx_latency = port2_rx_latency_q;

  //////////////////////////////////////////////////////////////////////
  // Stamp slot decode for host access
  always @* begin
    wr_slot_d = 3'h0;
    wr_hi_d = 1'b0;
    rd_slot_d = 2'h3;
    rd_hi_d = 1'b0;
    case (i_addr)
      `PTPTR_OFS_P1_DREQ_LO: begin
        wr_slot_d = 3'h1;
        rd_slot_d = `PTPTR_SLOT_DREQ;
      end
      `PTPTR_OFS_P1_DREQ_HI: begin
        wr_slot_d = 3'h1;
        wr_hi_d = 1'b1;
        rd_slot_d = `PTPTR_SLOT_DREQ;
        rd_hi_d = 1'b1;
      end
      `PTPTR_OFS_P1_SYNC_LO: begin
        wr_slot_d = 3'h2;
        rd_slot_d = `PTPTR_SLOT_SYNC;
      end
      `PTPTR_OFS_P1_SYNC_HI: begin
        wr_slot_d = 3'h2;
        wr_hi_d = 1'b1;
        rd_slot_d = `PTPTR_SLOT_SYNC;
        rd_hi_d = 1'b1;
      end
      `PTPTR_OFS_P1_PRSP_LO: begin
        wr_slot_d = 3'h4;
        rd_slot_d = `PTPTR_SLOT_PRSP;
      end
      `PTPTR_OFS_P1_PRSP_HI: begin
        wr_slot_d = 3'h4;
        wr_hi_d = 1'b1;
        rd_slot_d = `PTPTR_SLOT_PRSP;
        rd_hi_d = 1'b1;
      end
      default: ;
    endcase
  end

  // Egress events pick their stamp slot
  assign cap = {i_egr_prsp, i_egr_sync, i_egr_dreq};

  ptptr_stamp_mem u_stamp (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_cap(cap),
    .i_cap_sec(i_egr_sec),
    .i_cap_ns(i_egr_ns),
    .i_wr(i_wr),
    .i_wr_slot(wr_slot_d),
    .i_wr_hi(wr_hi_d),
    .i_wr_data(i_wdata),
    .i_rd_slot(rd_slot_d),
    .i_rd_hi(rd_hi_d),
    .o_rd_data(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////
  // Config read path registered to line up with the stamp memory
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cfg_rdata_q <= `PTPTR_RST_ZERO;
      cfg_hit_q <= 1'b0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      cfg_hit_q <= 1'b1;
      case (i_addr)
        `PTPTR_OFS_P1_RX_LAT: cfg_rdata_q <= port1_rx_latency_q;
        `PTPTR_OFS_P1_TX_LAT: cfg_rdata_q <= port1_tx_latency_q;
        `PTPTR_OFS_P1_ASYM: cfg_rdata_q <= port1_asymmetry_correction_q;
        `PTPTR_OFS_P1_LINK_DLY: cfg_rdata_q <= port1_link_delay_q;
        `PTPTR_OFS_P2_RX_LAT: cfg_rdata_q <= port2_rx_latency_q;
        default: begin
          cfg_rdata_q <= 16'h0000;
          cfg_hit_q <= 1'b0;
        end
      endcase
    end
  end

  // Unmapped and reserved addresses read as zero
  always @* begin
    o_rdata = cfg_hit_q ? cfg_rdata_q : mem_rdata;
  end

  //////////////////////////////////////////////////////////////////////
  // Sign-magnitude to two's complement, 64-bit correction field
  always @* begin
    if (port1_asymmetry_correction_q[`PTPTR_ASYM_SIGN]) begin
      asym_ext = 64'h0 - {49'h0, port1_asymmetry_correction_q[14:0]};
    end else begin
      asym_ext = {49'h0, port1_asymmetry_correction_q[14:0]};
    end
  end

  // Correction update; one cycle latency, caller tags message class
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_corr_out <= 64'h0;
      o_corr_valid <= 1'b0;
    end else begin
      o_corr_valid <= i_corr_valid;
      if (i_corr_valid) begin
        if (i_corr_ingress) begin
          o_corr_out <= i_corr_in + asym_ext;
        end else begin
          o_corr_out <= i_corr_in - asym_ext;
        end
      end
    end
  end
endmodule // ptptr_regs
`default_nettype wire

// file: hw/ptptr_regs.vh
`ifndef PTPTR_REGS_VH
`define PTPTR_REGS_VH
// Register byte offsets (16-bit registers, even addresses)
`define PTPTR_OFS_P1_RX_LAT 12'h640
`define PTPTR_OFS_P1_TX_LAT 12'h642
`define PTPTR_OFS_P1_ASYM 12'h644
`define PTPTR_OFS_P1_LINK_DLY 12'h646
`define PTPTR_OFS_P1_DREQ_LO 12'h648
`define PTPTR_OFS_P1_DREQ_HI 12'h64A
`define PTPTR_OFS_P1_SYNC_LO 12'h64C
`define PTPTR_OFS_P1_SYNC_HI 12'h64E
`define PTPTR_OFS_P1_PRSP_LO 12'h650
`define PTPTR_OFS_P1_PRSP_HI 12'h652
`define PTPTR_OFS_P2_RX_LAT 12'h660
// Reset values
`define PTPTR_RST_RX_LAT 16'h019F
`define PTPTR_RST_TX_LAT 16'h002D
`define PTPTR_RST_ZERO 16'h0000
// Field positions
`define PTPTR_ASYM_SIGN 15
`define PTPTR_HI_SEC_MSB 15
`define PTPTR_HI_SEC_LSB 14
`define PTPTR_HI_NS_MSB 13
// Stamp slot indices
`define PTPTR_SLOT_DREQ 2'h0
`define PTPTR_SLOT_SYNC 2'h1
`define PTPTR_SLOT_PRSP 2'h2
`endif

// file: hw/ptptr_stamp_mem.v
`timescale 1ns/100ps
`default_nettype none
// Three egress stamp slots, each a low/high word pair
module ptptr_stamp_mem (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [2:0] i_cap,
  input wire [1:0] i_cap_sec,
  input wire [29:0] i_cap_ns,
  input wire i_wr,
  input wire [2:0] i_wr_slot,
  input wire i_wr_hi,
  input wire [15:0] i_wr_data,
  input wire [1:0] i_rd_slot,
  input wire i_rd_hi,
  output reg [15:0] o_rd_data
);
  reg [15:0] lo_q [0:2];
  reg [15:0] hi_q [0:2];
  genvar g;
  //////////////////////////////////////////////////////////////////////
  // Capture beats a same-cycle host write so no stamp is lost
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_slot
      always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          lo_q[g] <= `PTPTR_RST_ZERO;
          hi_q[g] <= `PTPTR_RST_ZERO;
        end else if (i_cap[g]) begin
          lo_q[g] <= i_cap_ns[15:0];
          hi_q[g] <= {i_cap_sec, i_cap_ns[29:16]};
        end else if (i_wr && i_wr_slot[g]) begin
          if (i_wr_hi) begin
            hi_q[g] <= i_wr_data;
          end else begin
            lo_q[g] <= i_wr_data;
          end
        end
      end
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////
  // Registered read port
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_rd_data <= `PTPTR_RST_ZERO;
    end else if (i_rd_slot == 2'h3) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd_hi) begin
      o_rd_data <= hi_q[i_rd_slot];
    end else begin
      o_rd_data <= lo_q[i_rd_slot];
    end
  end
endmodule // ptptr_stamp_mem
`default_nettype wire

// file: sim/ptptr_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the register bus, one access at a time
module ptptr_host (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [11:0] o_addr = 12'h000,
  output logic [15:0] o_wdata = 16'h0000
);
  // Data is inverted on release so a stale value never looks valid
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge i_clk_sys);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= v;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_wdata <= ~v;
  endtask
  // Address held until the edge that sees the answer
  task automatic rd(input logic [11:0] a, output logic [15:0] v);
    @(posedge i_clk_sys);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    // Answer is taken mid-cycle, where it is settled, not in the launch step
    @(negedge i_clk_sys);
    v = i_rvalid ? i_rdata : 16'hXXXX;
    @(posedge i_clk_sys);
    o_addr <= ~a;
  endtask
endmodule // ptptr_host
`default_nettype wire

// file: sim/ptptr_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ptptr_regs_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [11:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_egr_dreq,
  input wire logic [1:0] i_egr_sec,
  input wire logic [29:0] i_egr_ns,
  input wire logic i_corr_valid,
  input wire logic o_corr_valid,
  input wire logic [15:0] o_port1_tx_latency,
  input wire logic [15:0] o_port1_rx_latency,
  input wire logic [15:0] o_port1_link_delay,
  input wire logic [15:0] o_port2_rx_latency
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  chk_read_answer: assert property (i_rd |=> o_rvalid) else $error("read not answered");
  chk_rvalid_cause: assert property (o_rvalid |-> $past(i_rd)) else $error("stray read valid");
  chk_reset_values: assert property (disable iff (1'b0) !i_rst_b |=>
    o_port1_tx_latency == 16'h002D && o_port1_link_delay == 16'h0000 &&
    o_port1_rx_latency == 16'h019F && o_port2_rx_latency == 16'h019F) else $error("reset value");
  chk_tx_write: assert property (i_wr && i_addr == 12'h642 |=>
    o_port1_tx_latency == $past(i_wdata)) else $error("tx latency write lost");
  chk_link_write: assert property (i_wr && i_addr == 12'h646 |=>
    o_port1_link_delay == $past(i_wdata)) else $error("link delay write lost");
  chk_corr_answer: assert property (i_corr_valid |=> o_corr_valid) else $error("no result");
  // Stamp read straight after the capture, nothing else touching the slot
  chk_stamp_low: assert property (i_egr_dreq ##1 (i_rd && i_addr == 12'h648 && !i_wr &&
    !i_egr_dreq) |=> o_rdata == 16'($past(i_egr_ns, 2))) else $error("stamp low word");
  chk_hole_read: assert property (i_rd && i_addr == 12'h654 |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule // ptptr_regs_sva
bind ptptr_regs ptptr_regs_sva i_sva (.*);
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb;
  logic i_clk_sys, i_rst_b, wr, rd, rv, e_dq, e_sy, e_pr, c_v, c_ing, c_ov;
  logic [11:0] addr;
  logic [15:0] wd, rdat, d;
  logic [1:0] sec;
  logic [29:0] ns;
  logic [63:0] c_in, c_out;
  logic [15:0] p1tx, p1rx, p1ld, p2rx;
  int miscompares = 0;
  int checks_done = 0;
  ptptr_regs i_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .i_egr_dreq(e_dq),
    .i_egr_sync(e_sy), .i_egr_prsp(e_pr), .i_egr_sec(sec), .i_egr_ns(ns), .i_corr_valid(c_v),
    .i_corr_ingress(c_ing), .i_corr_in(c_in), .o_corr_out(c_out), .o_corr_valid(c_ov),
    .o_port1_tx_latency(p1tx), .o_port1_rx_latency(p1rx), .o_port1_link_delay(p1ld),
    .o_port2_rx_latency(p2rx));
  ptptr_host i_host (.i_clk_sys(i_clk_sys), .i_rdata(rdat), .i_rvalid(rv), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wd));
  ////////////////////////////////////////
  task automatic t_reset_values();
    for (int i = 0; i < 10; i++) begin
      i_host.rd((i == 9) ? 12'h660 : 12'h640 + 12'(2 * i), d);
      `CHK(d, (i == 0 || i == 9) ? 16'h019F : (i == 1) ? 16'h002D : 16'h0000)
    end
  endtask
  task automatic t_write_back();
    logic [11:0] al [4] = '{12'h640, 12'h642, 12'h646, 12'h660};
    foreach (al[i]) begin
      i_host.wr(al[i], 16'hC3A0 + 16'(i));
      i_host.rd(al[i], d);
      `CHK(d, 16'hC3A0 + 16'(i))
    end
    // Level outputs must follow the written registers
    `CHK({p1rx, p1tx, p1ld, p2rx}, {16'hC3A0, 16'hC3A1, 16'hC3A2, 16'hC3A3})
    // Hole in the map: write dropped, read zero is judged by the checker
    i_host.wr(12'h654, 16'hFFFF);
    i_host.rd(12'h654, d);
  endtask
  // Read issued the cycle after the capture to hit the tightest case
  task automatic t_stamps();
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk_sys);
      {e_pr, e_sy, e_dq} <= 3'(1 << k);
      sec <= 2'(k + 1);
      ns <= 30'h2ABC1234 + 30'(k);
      fork
        i_host.rd(12'h648 + 12'(4 * k), d);
        begin
          @(posedge i_clk_sys);
          {e_pr, e_sy, e_dq} <= 3'h0;
          ns <= ~ns;
          sec <= ~sec;
        end
      join
      `CHK(d, 16'h1234 + 16'(k))
      i_host.rd(12'h64A + 12'(4 * k), d);
      `CHK(d, {2'(k + 1), 14'h2ABC})
    end
  endtask
  task automatic t_corr(input logic [15:0] asym, input logic ing, input logic [63:0] ex);
    i_host.wr(12'h644, asym);
    @(posedge i_clk_sys);
    c_v <= 1'b1;
    c_ing <= ing;
    c_in <= 64'h3E8;
    @(posedge i_clk_sys);
    c_v <= 1'b0;
    c_in <= ~c_in;
    @(negedge i_clk_sys);
    `CHK({c_ov, c_out}, {1'b1, ex})
  endtask
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("Checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // Whole run is about a hundred cycles; this is ample
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {i_rst_b, e_dq, e_sy, e_pr, c_v, c_ing, sec, ns, c_in} = '0;
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_reset_values();
    t_write_back();
    t_stamps();
    t_corr(16'h0064, 1'b1, 64'h44C);
    t_corr(16'h0064, 1'b0, 64'h384);
    t_corr(16'h8064, 1'b1, 64'h384);
    t_corr(16'h8064, 1'b0, 64'h44C);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
